// *** hw/lsdr_top.sv ***
`timescale 1ns/1ps
// Behaviour
// - Sleep select 00 uses normal code; 11 uses sleep code while sleep pin low.
// - Factory setting picks first or second sleep input as each LDO sleep pin.
// - LDO control bit 0 low turns rail off regardless of control pins.
// - Enabled regulator has its discharge field forced to 00 by hardware.
// - Discharge codes: 00 none, 01 100 ohm, 10 200 ohm, 11 500 ohm.
// - Buck discharge fields: fourth 7:6, third 5:4, second 3:2, first 1:0.
// - LDO control bits 7:6 are read-only zero.
module lsdr_top
   import lsdr_pkg::*;
#(
   parameter int VID_W = 8
) (
   // Clock and reset
   input  wire logic                    I_CORE_CLK,
   input  wire logic                    I_SYS_RST,
   // Register port from serial interface
   input  wire logic                    I_REG_WR,
   input  wire logic [7:0]              I_REG_ADDR,
   input  wire logic [7:0]              I_REG_WDATA,
   output logic      [7:0]              O_REG_RDATA,
   output logic                         O_REG_HIT,
   // Factory configuration
   input  wire logic [7:0]              I_CFG_LDO2_CTRL,
   input  wire logic [7:0]              I_CFG_LDO3_CTRL,
   input  wire logic [7:0]              I_CFG_BUCK_DISCH,
   input  wire logic                    I_CFG_LDO2_PIN_SEL,
   input  wire logic                    I_CFG_LDO3_PIN_SEL,
   // Sleep pins and voltage codes
   input  wire logic                    I_FIRST_SLEEP_INPUT,
   input  wire logic                    I_SECOND_SLEEP_INPUT,
   input  wire logic [VID_W-1:0]        I_SECOND_LDO_NORMAL_VOLTAGE_CODE,
   input  wire logic [VID_W-1:0]        I_SECOND_LDO_SLEEP_VOLTAGE_CODE,
   input  wire logic [VID_W-1:0]        I_THIRD_LDO_NORMAL_VOLTAGE_CODE,
   input  wire logic [VID_W-1:0]        I_THIRD_LDO_SLEEP_VOLTAGE_CODE,
   // Buck enable state
   input  wire logic [LSDR_NUM_BUCK-1:0] I_BUCK_ENABLED,
   // Rail outputs
   output logic                         O_SECOND_LDO_SW_ENABLE,
   output logic                         O_THIRD_LDO_SW_ENABLE,
   output logic      [VID_W-1:0]        O_SECOND_LDO_VOLTAGE_CODE,
   output logic      [VID_W-1:0]        O_THIRD_LDO_VOLTAGE_CODE,
   output logic      [7:0]              O_BUCK_DISCHARGE_SEL
);
   // ==========================================================
   // Decode
   logic       wr_ldo2;
   logic       wr_ldo3;
   logic       wr_disch;
   logic [7:0] ldo2_rdata;
   logic [7:0] ldo3_rdata;
   logic [7:0] disch_q;
   logic [7:0] disch_d;

   assign wr_ldo2  = I_REG_WR && (I_REG_ADDR == LSDR_OFS_LDO2_CTRL);
   assign wr_ldo3  = I_REG_WR && (I_REG_ADDR == LSDR_OFS_LDO3_CTRL);
   assign wr_disch = I_REG_WR && (I_REG_ADDR == LSDR_OFS_BUCK_DISCH);

   // ==========================================================
   // LDO control registers
   lsdr_ldo_ctrl #(.VID_W(VID_W)) u_ldo2 (
      .i_clk                 (I_CORE_CLK),
      .i_rst                 (I_SYS_RST),
      .i_wr                  (wr_ldo2),
      .i_wdata               (I_REG_WDATA),
      .i_reset_value         (I_CFG_LDO2_CTRL),
      .o_rdata               (ldo2_rdata),
      .i_pin_sel             (I_CFG_LDO2_PIN_SEL),
      .i_first_sleep_input   (I_FIRST_SLEEP_INPUT),
      .i_second_sleep_input  (I_SECOND_SLEEP_INPUT),
      .i_normal_voltage_code (I_SECOND_LDO_NORMAL_VOLTAGE_CODE),
      .i_sleep_voltage_code  (I_SECOND_LDO_SLEEP_VOLTAGE_CODE),
      .o_sw_enable           (O_SECOND_LDO_SW_ENABLE),
      .o_voltage_code        (O_SECOND_LDO_VOLTAGE_CODE)
   );

   lsdr_ldo_ctrl #(.VID_W(VID_W)) u_ldo3 (
      .i_clk                 (I_CORE_CLK),
      .i_rst                 (I_SYS_RST),
      .i_wr                  (wr_ldo3),
      .i_wdata               (I_REG_WDATA),
      .i_reset_value         (I_CFG_LDO3_CTRL),
      .o_rdata               (ldo3_rdata),
      .i_pin_sel             (I_CFG_LDO3_PIN_SEL),
      .i_first_sleep_input   (I_FIRST_SLEEP_INPUT),
      .i_second_sleep_input  (I_SECOND_SLEEP_INPUT),
      .i_normal_voltage_code (I_THIRD_LDO_NORMAL_VOLTAGE_CODE),
      .i_sleep_voltage_code  (I_THIRD_LDO_SLEEP_VOLTAGE_CODE),
      .o_sw_enable           (O_THIRD_LDO_SW_ENABLE),
      .o_voltage_code        (O_THIRD_LDO_VOLTAGE_CODE)
   );

   // ==========================================================
   // Buck discharge register
   // Bits kept per buck; an enabled buck loses its whole field
   function automatic logic [7:0] disch_keep_mask(input logic [LSDR_NUM_BUCK-1:0] en);
      logic [7:0] m;
      m = 8'hFF;
      for (int b = 0; b < LSDR_NUM_BUCK; b++) begin
         if (en[b]) begin
            m[b*LSDR_DISCH_W +: LSDR_DISCH_W] = LSDR_DISCH_NONE;
         end
      end
      return m;
   endfunction : disch_keep_mask

   // Clear on enable beats a same-cycle software write
   always_comb begin
      disch_d = (wr_disch ? I_REG_WDATA : disch_q) & disch_keep_mask(I_BUCK_ENABLED);
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_SYS_RST) begin
         // Enabled rails stay clear even while the factory word loads
         disch_q <= I_CFG_BUCK_DISCH & disch_keep_mask(I_BUCK_ENABLED);
      end else begin
         disch_q <= disch_d;
      end
   end

   // Codes pass straight to the analog pull-down selector
   assign O_BUCK_DISCHARGE_SEL = disch_q;

   // ==========================================================
   // Read mux
   always_comb begin
      O_REG_HIT   = 1'b1;
      if (I_REG_ADDR == LSDR_OFS_LDO2_CTRL) begin
         O_REG_RDATA = ldo2_rdata;
      end else if (I_REG_ADDR == LSDR_OFS_LDO3_CTRL) begin
         O_REG_RDATA = ldo3_rdata;
      end else if (I_REG_ADDR == LSDR_OFS_BUCK_DISCH) begin
         O_REG_RDATA = disch_q;
      end else begin
         O_REG_RDATA = 8'h00;
         O_REG_HIT   = 1'b0;
      end
   end
endmodule : lsdr_top

// *** hw/lsdr_pkg.sv ***
package lsdr_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] LSDR_OFS_LDO2_CTRL   = 8'h28;
   localparam logic [7:0] LSDR_OFS_LDO3_CTRL   = 8'h29;
   localparam logic [7:0] LSDR_OFS_BUCK_DISCH  = 8'h40;
   // ==========================================================
   // LDO control fields
   localparam int         LSDR_SLP_SEL_LSB     = 4;
   localparam int         LSDR_SLP_SEL_MSB     = 5;
   localparam int         LSDR_RSV_LSB         = 1;
   localparam int         LSDR_RSV_MSB         = 3;
   localparam int         LSDR_SW_EN_BIT       = 0;
   localparam logic [1:0] LSDR_SLP_OFF         = 2'h0;
   localparam logic [1:0] LSDR_SLP_ON          = 2'h3;
   localparam logic [2:0] LSDR_RSV_PATTERN     = 3'h6;
   localparam logic [1:0] LSDR_RO_ZERO         = 2'h0;
   // ==========================================================
   // Discharge fields
   localparam int         LSDR_NUM_BUCK        = 4;
   localparam int         LSDR_DISCH_W         = 2;
   localparam logic [1:0] LSDR_DISCH_NONE      = 2'h0;
   localparam logic [1:0] LSDR_DISCH_100R      = 2'h1;
   localparam logic [1:0] LSDR_DISCH_200R      = 2'h2;
   localparam logic [1:0] LSDR_DISCH_500R      = 2'h3;
   // ==========================================================
   // Sleep pin choice
   typedef enum logic {LSDR_PIN_FIRST, LSDR_PIN_SECOND} lsdr_pin_t;
endpackage : lsdr_pkg

// *** hw/lsdr_ldo_ctrl.sv ***
`timescale 1ns/1ps
module lsdr_ldo_ctrl
   import lsdr_pkg::*;
#(
   parameter int VID_W = 8
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   // Register access
   input  wire logic             i_wr,
   input  wire logic [7:0]       i_wdata,
   input  wire logic [7:0]       i_reset_value,
   output logic      [7:0]       o_rdata,
   // Rail control
   input  wire logic             i_pin_sel,
   input  wire logic             i_first_sleep_input,
   input  wire logic             i_second_sleep_input,
   input  wire logic [VID_W-1:0] i_normal_voltage_code,
   input  wire logic [VID_W-1:0] i_sleep_voltage_code,
   output logic                  o_sw_enable,
   output logic      [VID_W-1:0] o_voltage_code
);
   logic [1:0] sleep_select_q;
   logic [2:0] rsv_q;
   logic       sw_enable_q;
   logic       sleep_pin;

   // Reset value is the factory configuration word
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sleep_select_q <= i_reset_value[LSDR_SLP_SEL_MSB:LSDR_SLP_SEL_LSB];
         rsv_q          <= i_reset_value[LSDR_RSV_MSB:LSDR_RSV_LSB];
         sw_enable_q    <= i_reset_value[LSDR_SW_EN_BIT];
      end else if (i_wr) begin
         sleep_select_q <= i_wdata[LSDR_SLP_SEL_MSB:LSDR_SLP_SEL_LSB];
         // Stored as written; software owes the fixed pattern
         rsv_q          <= i_wdata[LSDR_RSV_MSB:LSDR_RSV_LSB];
         sw_enable_q    <= i_wdata[LSDR_SW_EN_BIT];
      end
   end

   assign sleep_pin = (i_pin_sel == LSDR_PIN_SECOND) ? i_second_sleep_input : i_first_sleep_input;

   // Reserved codes fall back to normal voltage, the safe side
   assign o_voltage_code = (sleep_select_q == LSDR_SLP_ON && !sleep_pin) ?
                           i_sleep_voltage_code : i_normal_voltage_code;
   assign o_sw_enable    = sw_enable_q;
   assign o_rdata        = {LSDR_RO_ZERO, sleep_select_q, rsv_q, sw_enable_q};
endmodule : lsdr_ldo_ctrl

// *** test/lsdr_chk.sv ***
`timescale 1ns/1ps
module lsdr_chk
   import lsdr_pkg::*;
#(
   parameter int VID_W = 8
) (
   input wire logic                     I_CORE_CLK,
   input wire logic                     I_SYS_RST,
   input wire logic                     I_REG_WR,
   input wire logic [7:0]               I_REG_ADDR,
   input wire logic [7:0]               I_REG_WDATA,
   input wire logic [7:0]               O_REG_RDATA,
   input wire logic [7:0]               I_CFG_BUCK_DISCH,
   input wire logic                     I_CFG_LDO2_PIN_SEL,
   input wire logic                     I_FIRST_SLEEP_INPUT,
   input wire logic                     I_SECOND_SLEEP_INPUT,
   input wire logic [VID_W-1:0]         I_SECOND_LDO_NORMAL_VOLTAGE_CODE,
   input wire logic [VID_W-1:0]         I_SECOND_LDO_SLEEP_VOLTAGE_CODE,
   input wire logic [LSDR_NUM_BUCK-1:0] I_BUCK_ENABLED,
   input wire logic                     O_SECOND_LDO_SW_ENABLE,
   input wire logic [VID_W-1:0]         O_SECOND_LDO_VOLTAGE_CODE,
   input wire logic [7:0]               O_BUCK_DISCHARGE_SEL
);
   wire logic [7:0] en_m = {{2{I_BUCK_ENABLED[3]}}, {2{I_BUCK_ENABLED[2]}},
                            {2{I_BUCK_ENABLED[1]}}, {2{I_BUCK_ENABLED[0]}}};
   wire logic       pin  = I_CFG_LDO2_PIN_SEL ? I_SECOND_SLEEP_INPUT : I_FIRST_SLEEP_INPUT;
   wire logic       l2   = I_REG_ADDR == LSDR_OFS_LDO2_CTRL;
   wire logic [1:0] sel  = O_REG_RDATA[5:4];
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_SYS_RST);
   chk_ldo_sleep_code: assert property (l2 && sel == LSDR_SLP_ON && !pin |->
      O_SECOND_LDO_VOLTAGE_CODE == I_SECOND_LDO_SLEEP_VOLTAGE_CODE) else $error("sleep code");
   chk_ldo_awake_code: assert property (l2 && sel == LSDR_SLP_ON && pin |->
      O_SECOND_LDO_VOLTAGE_CODE == I_SECOND_LDO_NORMAL_VOLTAGE_CODE) else $error("awake code");
   chk_ldo_normal_code: assert property (l2 && sel == LSDR_SLP_OFF |->
      O_SECOND_LDO_VOLTAGE_CODE == I_SECOND_LDO_NORMAL_VOLTAGE_CODE) else $error("normal code");
   chk_sw_enable_bit: assert property (I_REG_WR && l2 |=> O_SECOND_LDO_SW_ENABLE == $past(I_REG_WDATA[0]))
      else $error("sw enable");
   chk_ro_zero: assert property (l2 || I_REG_ADDR == LSDR_OFS_LDO3_CTRL |-> O_REG_RDATA[7:6] == 2'h0)
      else $error("ro bits");
   chk_disch_clear: assert property (1'b1 |=> (O_BUCK_DISCHARGE_SEL & $past(en_m)) == 8'h00)
      else $error("discharge clear");
   chk_disch_write: assert property (I_REG_WR && I_REG_ADDR == LSDR_OFS_BUCK_DISCH && I_BUCK_ENABLED == 4'h0
      |=> O_BUCK_DISCHARGE_SEL == $past(I_REG_WDATA)) else $error("discharge write");
   chk_disch_read: assert property (I_REG_ADDR == LSDR_OFS_BUCK_DISCH |-> O_REG_RDATA == O_BUCK_DISCHARGE_SEL)
      else $error("discharge read");
   chk_cfg_load: assert property ($past(I_SYS_RST) && $past(I_BUCK_ENABLED) == 4'h0
      |-> O_BUCK_DISCHARGE_SEL == $past(I_CFG_BUCK_DISCH)) else $error("reset load");
   cov_ldo_write: cover property (I_REG_WR && l2);
   cov_sleep: cover property (l2 && sel == LSDR_SLP_ON && !pin);
   cov_enable: cover property ($rose(I_BUCK_ENABLED[2]));
endmodule : lsdr_chk

// *** test/lsdr_host.sv ***
`timescale 1ns/1ps
module lsdr_host
   import lsdr_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr = 1'b0,
   output logic      [7:0] o_addr = 8'h00,
   output logic      [7:0] o_wdata = 8'h00
);
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask : put
   // Only legal select codes and the fixed reserved pattern are ever sent
   task automatic ldo(input logic [7:0] a, input logic [1:0] sel, input logic en);
      put(a, {2'h0, (sel == LSDR_SLP_ON) ? LSDR_SLP_ON : LSDR_SLP_OFF, LSDR_RSV_PATTERN, en});
   endtask : ldo
   task automatic get(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      @(negedge i_clk);
      d = i_rdata;
   endtask : get
endmodule : lsdr_host

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
   import lsdr_pkg::*;
   logic       I_CORE_CLK = 1'b0, I_SYS_RST = 1'b1, I_REG_WR, I_FIRST_SLEEP_INPUT = 1'b1, I_SECOND_SLEEP_INPUT = 1'b1;
   logic [7:0] I_REG_ADDR, I_REG_WDATA, O_REG_RDATA, rd, v = 8'h5A;
   logic       O_REG_HIT, O_SECOND_LDO_SW_ENABLE, O_THIRD_LDO_SW_ENABLE;
   logic [7:0] O_SECOND_LDO_VOLTAGE_CODE, O_THIRD_LDO_VOLTAGE_CODE, O_BUCK_DISCHARGE_SEL;
   logic [3:0] I_BUCK_ENABLED = 4'h0;
   wire  [7:0] I_CFG_LDO2_CTRL = 8'hCD, I_CFG_LDO3_CTRL = 8'h0C, I_CFG_BUCK_DISCH = 8'h55;
   wire        I_CFG_LDO2_PIN_SEL = 1'b0, I_CFG_LDO3_PIN_SEL = 1'b1;
   wire  [7:0] I_SECOND_LDO_NORMAL_VOLTAGE_CODE = v, I_SECOND_LDO_SLEEP_VOLTAGE_CODE = ~v;
   wire  [7:0] I_THIRD_LDO_NORMAL_VOLTAGE_CODE = v ^ 8'h0F, I_THIRD_LDO_SLEEP_VOLTAGE_CODE = v ^ 8'hF0;
   int         n_mismatch = 0, num_checks = 0;
   always #4 I_CORE_CLK = ~I_CORE_CLK;
   lsdr_top dut (.*);
   lsdr_host host (.i_clk(I_CORE_CLK), .i_rdata(O_REG_RDATA), .o_wr(I_REG_WR),
                   .o_addr(I_REG_ADDR), .o_wdata(I_REG_WDATA));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host.get(a, rd);
      chk(rd, exp);
   endtask : rchk
   // Codes move with every pin change so a stale mux cannot match
   task automatic pins(input logic f, input logic s);
      @(posedge I_CORE_CLK);
      I_FIRST_SLEEP_INPUT <= f;
      I_SECOND_SLEEP_INPUT <= s;
      v <= v + 8'h11;
      @(negedge I_CORE_CLK);
   endtask : pins
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   initial begin
      repeat (10) @(posedge I_CORE_CLK);
      I_SYS_RST <= 1'b0;
      rchk(LSDR_OFS_LDO2_CTRL, 8'h0D);
      rchk(LSDR_OFS_LDO3_CTRL, 8'h0C);
      rchk(LSDR_OFS_BUCK_DISCH, 8'h55);
      rchk(8'h30, 8'h00);
      chk({7'h0, O_REG_HIT}, 8'h00);
      $display("test reset values done");
      host.ldo(LSDR_OFS_LDO2_CTRL, LSDR_SLP_ON, 1'b1);
      host.ldo(LSDR_OFS_LDO3_CTRL, LSDR_SLP_ON, 1'b0);
      rchk(LSDR_OFS_LDO3_CTRL, 8'h3C);
      rchk(LSDR_OFS_LDO2_CTRL, 8'h3D);
      chk({7'h0, O_REG_HIT}, 8'h01);
      host.put(LSDR_OFS_LDO2_CTRL, 8'hFD);
      rchk(LSDR_OFS_LDO2_CTRL, 8'h3D);
      chk({6'h0, O_THIRD_LDO_SW_ENABLE, O_SECOND_LDO_SW_ENABLE}, 8'h01);
      pins(1'b0, 1'b1);
      chk(O_SECOND_LDO_VOLTAGE_CODE, ~v);
      chk(O_THIRD_LDO_VOLTAGE_CODE, v ^ 8'h0F);
      pins(1'b1, 1'b0);
      chk(O_SECOND_LDO_VOLTAGE_CODE, v);
      chk(O_THIRD_LDO_VOLTAGE_CODE, v ^ 8'hF0);
      host.ldo(LSDR_OFS_LDO2_CTRL, LSDR_SLP_OFF, 1'b1);
      pins(1'b0, 1'b0);
      chk(O_SECOND_LDO_VOLTAGE_CODE, v);
      $display("test ldo control done");
      for (int c = 0; c < 4; c++) begin
         host.put(LSDR_OFS_BUCK_DISCH, {4{c[1:0]}});
         rchk(LSDR_OFS_BUCK_DISCH, {4{c[1:0]}});
      end
      host.put(LSDR_OFS_BUCK_DISCH, 8'hE4);
      rchk(LSDR_OFS_BUCK_DISCH, 8'hE4);
      @(posedge I_CORE_CLK);
      I_BUCK_ENABLED <= 4'h4;
      rchk(LSDR_OFS_BUCK_DISCH, 8'hC4);
      host.put(LSDR_OFS_BUCK_DISCH, 8'hFF);
      rchk(LSDR_OFS_BUCK_DISCH, 8'hCF);
      chk(O_BUCK_DISCHARGE_SEL, 8'hCF);
      $display("test discharge done");
      results;
   end
   initial begin
      #(3000 * 8);
      n_mismatch++;
      results;
   end
endmodule : tb
bind lsdr_top lsdr_chk #(.VID_W(VID_W)) chk_i (.*);
